/* File: core/spc_fifo.sv */
// Synchronous valid/ready FIFO for captured pixel words
`timescale 1ns/100ps
`default_nettype none
module spc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and flush
	input  wire logic             clk_i,
	input  wire logic             flush_i,
	// Filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
	logic [AW:0]      count_reg, count_next;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count
	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem[rd_ptr_reg];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Pointer and count update, wrapping for any depth
	always_comb
	begin
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next  = count_reg;
		if (push)
			wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
		if (pop)
			rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
		if (push && !pop)
			count_next = count_reg + (AW+1)'(1);
		else if (pop && !push)
			count_next = count_reg - (AW+1)'(1);
	end

	always_ff @(posedge clk_i)
	begin
		if (flush_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	// Storage needs no reset; only counted words are ever read
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data_i;
	end

endmodule : spc_fifo
`default_nettype wire

/* File: core/spc_pkg.sv */
// Constants and types for the power-mode and pixel-clock-edge controller
package spc_pkg;

	// Clock and widths
	localparam int CLK_HZ        = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int DATA_W        = 16;
	localparam int FIFO_DEPTH    = 8;

	// Loss timeouts, least times rounded up to whole cycles
	localparam int         PCLK_TIMEOUT_NS    = 2000;
	localparam int         STREAM_TIMEOUT_NS  = 5000;
	localparam logic [7:0] PCLK_TIMEOUT_CYC   =
		8'((PCLK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] STREAM_TIMEOUT_CYC =
		8'((STREAM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Lock acquisition counts
	localparam logic [3:0] SER_LOCK_EDGES = 4'h8;
	localparam logic [3:0] DES_LOCK_WORDS = 4'h8;

	// Spread-spectrum modulation rates and triangle depth
	localparam int         SSC_RATE_MIN_HZ = 9000;
	localparam int         SSC_RATE_LO_HZ  = 25000;
	localparam int         SSC_RATE_HI_HZ  = 45000;
	localparam int         SSC_RATE_MAX_HZ = 66000;
	localparam int         SSC_TRI_STEPS   = 8;
	localparam logic [3:0] SSC_TRI_MAX     = 4'h8;
	localparam logic [7:0] SSC_STEP_CYC_0  = 8'(CLK_HZ / (SSC_RATE_MIN_HZ * 2 * SSC_TRI_STEPS));
	localparam logic [7:0] SSC_STEP_CYC_1  = 8'(CLK_HZ / (SSC_RATE_LO_HZ * 2 * SSC_TRI_STEPS));
	localparam logic [7:0] SSC_STEP_CYC_2  = 8'(CLK_HZ / (SSC_RATE_HI_HZ * 2 * SSC_TRI_STEPS));
	localparam logic [7:0] SSC_STEP_CYC_3  = 8'(CLK_HZ / (SSC_RATE_MAX_HZ * 2 * SSC_TRI_STEPS));

	// Output pixel clock and stagger window
	localparam logic [5:0] DES_HALF_BASE  = 6'h10;
	localparam int         STAGGER_GROUPS = 4;
	localparam int         STAGGER_GRP_W  = 4;
	localparam logic [1:0] STAGGER_LAST   = 2'h3;

	// Reset values
	localparam logic [7:0] LFSR_SEED = 8'h01;
	localparam logic [6:0] RD_RESET  = 7'h00;

	// Word on the serial link
	typedef struct packed {
		logic              ctrl;
		logic              inv;
		logic [DATA_W-1:0] data;
	} spc_link_word_type;

	localparam spc_link_word_type TX_STATIC_HIGH = '{ctrl: 1'b1, inv: 1'b1, data: 16'hFFFF};

	// Spread-spectrum settings
	typedef struct packed {
		logic       enable;
		logic [1:0] rate_sel;
		logic [1:0] dev_sel;
	} spc_ssc_cfg_type;

	typedef enum logic [1:0] {SER_OFF, SER_ACQUIRE, SER_ACTIVE, SER_ON_OSC} spc_ser_state_type;
	typedef enum logic [1:0] {DES_OFF, DES_SLEEP, DES_ACQUIRE, DES_LOCKED} spc_des_state_type;

endpackage : spc_pkg

/* File: core/spc_power_edge_ctrl.sv */
// Power modes, pixel-clock edges and output shaping for the serial link pair
`timescale 1ns/100ps
`default_nettype none
module spc_power_edge_ctrl
	import spc_pkg::*;
(
	// Clock and reset
	input  wire logic               ref_clk_i,
	input  wire logic               reset_i,
	// Serializer control
	input  wire logic               ser_powerdown_n_pin_i,
	input  wire logic               ser_auto_mode_i,
	input  wire logic               tx_clock_edge_select_i,
	// Serializer pixel input
	input  wire logic               pclk_i,
	input  wire logic [DATA_W-1:0]  pixel_data_i,
	// Serializer link output
	output spc_link_word_type       tx_word_o,
	output logic                    tx_valid_o,
	input  wire logic               tx_ready_i,
	// Serializer status
	output logic                    ser_locked_o,
	output logic                    ser_on_osc_o,
	output logic                    ser_overflow_o,
	output logic                    ser_fifo_ready_o,
	// Deserializer control
	input  wire logic               des_powerdown_n_pin_i,
	input  wire logic               des_auto_mode_i,
	input  wire logic               rx_clock_edge_select_i,
	input  wire logic               output_sleep_state_select_i,
	input  wire logic [2:0]         receive_equalizer_level_i,
	input  wire logic               stagger_enable_i,
	input  wire spc_ssc_cfg_type    spread_spectrum_clock_gen_i,
	// Deserializer link input
	input  wire spc_link_word_type  rx_word_i,
	input  wire logic               rx_valid_i,
	// Deserializer outputs
	output logic                    des_pclk_o,
	output logic      [DATA_W-1:0]  des_data_o,
	output logic                    des_lock_o,
	output logic                    des_powered_down_o,
	output logic      [2:0]         receive_equalizer_o
);

	// Ones count of a data word, for the balance decision
	function automatic logic [4:0] ones_count(input logic [DATA_W-1:0] w);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < DATA_W; i++)
			n = n + 5'(w[i]);
		return n;
	endfunction : ones_count

	// Serializer state
	spc_ser_state_type ser_state_reg, ser_state_next;
	logic              pclk_prev_reg, pclk_prev_next;
	logic [7:0]        pclk_idle_reg, pclk_idle_next;
	logic [3:0]        ser_lock_cnt_reg, ser_lock_cnt_next;
	logic              overflow_reg, overflow_next;
	logic              fifo_ready_reg, fifo_ready_next;
	spc_link_word_type tx_word_reg, tx_word_next;
	logic              tx_valid_reg, tx_valid_next;
	logic [6:0]        rd_reg, rd_next;
	logic              ser_locked_reg, ser_locked_next;
	logic              on_osc_reg, on_osc_next;

	// Serializer helpers
	logic              pclk_toggle;
	logic              pclk_edge;
	logic              pclk_lost;
	logic              fifo_push;
	logic              fifo_pop;
	logic              fifo_flush;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	logic              tx_free;
	logic [DATA_W-1:0] enc_data;
	logic [6:0]        enc_disp;
	logic              enc_inv;

	assign pclk_toggle = (pclk_i != pclk_prev_reg);
	assign pclk_edge   = tx_clock_edge_select_i ? (pclk_i && !pclk_prev_reg)
	                                            : (!pclk_i && pclk_prev_reg);
	assign pclk_lost   = (pclk_idle_reg == PCLK_TIMEOUT_CYC);
	assign fifo_push   = (ser_state_reg == SER_ACTIVE) && pclk_edge;
	assign tx_free     = !tx_valid_reg || tx_ready_i;
	assign fifo_pop    = (ser_state_reg == SER_ACTIVE) && tx_free && fifo_out_valid;
	assign fifo_flush  = reset_i || (ser_state_reg == SER_OFF);

	// Pixel words wait here while the link stalls; a full FIFO drops pixels
	spc_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_pixel_fifo (
		.clk_i       (ref_clk_i),
		.flush_i     (fifo_flush),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (pixel_data_i),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data)
	);

	// Word to send: a pixel when active, an idle fill word otherwise
	always_comb
	begin
		enc_data = fifo_pop ? fifo_out_data : '0;
		enc_disp = 7'({1'b0, ones_count(enc_data), 1'b0}) - 7'h10;
		enc_inv  = (enc_disp != 7'h00) && (rd_reg[6] == enc_disp[6]);
	end

	// Serializer link state machine and transmit stage
	always_comb
	begin
		ser_state_next    = ser_state_reg;
		pclk_prev_next    = pclk_i;
		pclk_idle_next    = pclk_toggle ? 8'h00 : (pclk_lost ? pclk_idle_reg : pclk_idle_reg + 8'h01);
		ser_lock_cnt_next = ser_lock_cnt_reg;
		overflow_next     = overflow_reg || (fifo_push && !fifo_in_ready);
		fifo_ready_next   = fifo_in_ready;
		tx_word_next      = tx_word_reg;
		tx_valid_next     = tx_valid_reg && !tx_ready_i;
		rd_next           = rd_reg;
		case (ser_state_reg)
			SER_OFF:
			begin
				ser_state_next    = SER_ACQUIRE;
				ser_lock_cnt_next = 4'h0;
			end
			SER_ACQUIRE:
			begin
				if (pclk_lost && ser_auto_mode_i)
					ser_state_next = SER_ON_OSC;
				else if (pclk_edge)
				begin
					if (ser_lock_cnt_reg == SER_LOCK_EDGES - 4'h1)
						ser_state_next = SER_ACTIVE;
					else
						ser_lock_cnt_next = ser_lock_cnt_reg + 4'h1;
				end
			end
			SER_ACTIVE:
			begin
				if (pclk_lost)
				begin
					ser_state_next    = ser_auto_mode_i ? SER_ON_OSC : SER_ACQUIRE;
					ser_lock_cnt_next = 4'h0;
				end
			end
			SER_ON_OSC:
			begin
				if (pclk_toggle)
				begin
					ser_state_next    = SER_ACQUIRE;
					ser_lock_cnt_next = 4'h0;
				end
			end
			default:
				ser_state_next = SER_OFF;
		endcase
		// Idle words keep the far end locked while running on the oscillator
		if (ser_state_reg == SER_OFF)
		begin
			tx_word_next  = TX_STATIC_HIGH;
			tx_valid_next = 1'b0;
		end
		else if (tx_free && (fifo_pop || ser_state_reg != SER_ACTIVE))
		begin
			tx_word_next.ctrl = !fifo_pop;
			tx_word_next.inv  = enc_inv;
			tx_word_next.data = enc_inv ? ~enc_data : enc_data;
			tx_valid_next     = 1'b1;
			rd_next           = enc_inv ? rd_reg - enc_disp : rd_reg + enc_disp;
		end
		ser_locked_next = (ser_state_next == SER_ACTIVE);
		on_osc_next     = (ser_state_next == SER_ON_OSC);
	end

	// Powerdown pin clears the serializer at once, without the clock
	always_ff @(posedge ref_clk_i or negedge ser_powerdown_n_pin_i)
	begin
		if (!ser_powerdown_n_pin_i)
		begin
			ser_state_reg    <= SER_OFF;
			pclk_prev_reg    <= 1'b0;
			pclk_idle_reg    <= 8'h00;
			ser_lock_cnt_reg <= 4'h0;
			overflow_reg     <= 1'b0;
			fifo_ready_reg   <= 1'b0;
			tx_word_reg      <= TX_STATIC_HIGH;
			tx_valid_reg     <= 1'b0;
			rd_reg           <= RD_RESET;
			ser_locked_reg   <= 1'b0;
			on_osc_reg       <= 1'b0;
		end
		else if (reset_i)
		begin
			ser_state_reg    <= SER_OFF;
			pclk_prev_reg    <= 1'b0;
			pclk_idle_reg    <= 8'h00;
			ser_lock_cnt_reg <= 4'h0;
			overflow_reg     <= 1'b0;
			fifo_ready_reg   <= 1'b0;
			tx_word_reg      <= TX_STATIC_HIGH;
			tx_valid_reg     <= 1'b0;
			rd_reg           <= RD_RESET;
			ser_locked_reg   <= 1'b0;
			on_osc_reg       <= 1'b0;
		end
		else
		begin
			ser_state_reg    <= ser_state_next;
			pclk_prev_reg    <= pclk_prev_next;
			pclk_idle_reg    <= pclk_idle_next;
			ser_lock_cnt_reg <= ser_lock_cnt_next;
			overflow_reg     <= overflow_next;
			fifo_ready_reg   <= fifo_ready_next;
			tx_word_reg      <= tx_word_next;
			tx_valid_reg     <= tx_valid_next;
			rd_reg           <= rd_next;
			ser_locked_reg   <= ser_locked_next;
			on_osc_reg       <= on_osc_next;
		end
	end

	assign tx_word_o        = tx_word_reg;
	assign tx_valid_o       = tx_valid_reg;
	assign ser_locked_o     = ser_locked_reg;
	assign ser_on_osc_o     = on_osc_reg;
	assign ser_overflow_o   = overflow_reg;
	assign ser_fifo_ready_o = fifo_ready_reg;

	// Deserializer link state
	spc_des_state_type des_state_reg, des_state_next;
	logic [7:0]        rx_idle_reg, rx_idle_next;
	logic [3:0]        des_lock_cnt_reg, des_lock_cnt_next;
	logic [DATA_W-1:0] hold_reg, hold_next;
	logic              lock_out_reg, lock_out_next;
	logic              pd_out_reg, pd_out_next;
	logic [2:0]        eq_reg, eq_next;
	logic              stream_lost;

	assign stream_lost = (rx_idle_reg == STREAM_TIMEOUT_CYC);

	// Receiver lock tracking; data is only taken once locked
	always_comb
	begin
		des_state_next    = des_state_reg;
		rx_idle_next      = rx_valid_i ? 8'h00 : (stream_lost ? rx_idle_reg : rx_idle_reg + 8'h01);
		des_lock_cnt_next = des_lock_cnt_reg;
		hold_next         = hold_reg;
		case (des_state_reg)
			DES_OFF:
			begin
				des_state_next    = DES_ACQUIRE;
				des_lock_cnt_next = 4'h0;
			end
			DES_SLEEP:
			begin
				if (rx_valid_i)
				begin
					des_state_next    = DES_ACQUIRE;
					des_lock_cnt_next = 4'h0;
				end
			end
			DES_ACQUIRE:
			begin
				if (stream_lost && des_auto_mode_i)
					des_state_next = DES_SLEEP;
				else if (rx_valid_i)
				begin
					if (des_lock_cnt_reg == DES_LOCK_WORDS - 4'h1)
						des_state_next = DES_LOCKED;
					else
						des_lock_cnt_next = des_lock_cnt_reg + 4'h1;
				end
			end
			DES_LOCKED:
			begin
				if (stream_lost)
				begin
					des_state_next    = des_auto_mode_i ? DES_SLEEP : DES_ACQUIRE;
					des_lock_cnt_next = 4'h0;
				end
				else if (rx_valid_i && !rx_word_i.ctrl)
					hold_next = rx_word_i.inv ? ~rx_word_i.data : rx_word_i.data;
			end
			default:
				des_state_next = DES_OFF;
		endcase
		lock_out_next = (des_state_next == DES_LOCKED);
		pd_out_next   = (des_state_next == DES_OFF) || (des_state_next == DES_SLEEP);
		// The equalizer rests while the receiver is powered down
		eq_next       = pd_out_next ? 3'h0 : receive_equalizer_level_i;
	end

	always_ff @(posedge ref_clk_i or negedge des_powerdown_n_pin_i)
	begin
		if (!des_powerdown_n_pin_i)
		begin
			des_state_reg    <= DES_OFF;
			rx_idle_reg      <= 8'h00;
			des_lock_cnt_reg <= 4'h0;
			hold_reg         <= '0;
			lock_out_reg     <= 1'b0;
			pd_out_reg       <= 1'b1;
			eq_reg           <= 3'h0;
		end
		else if (reset_i)
		begin
			des_state_reg    <= DES_OFF;
			rx_idle_reg      <= 8'h00;
			des_lock_cnt_reg <= 4'h0;
			hold_reg         <= '0;
			lock_out_reg     <= 1'b0;
			pd_out_reg       <= 1'b1;
			eq_reg           <= 3'h0;
		end
		else
		begin
			des_state_reg    <= des_state_next;
			rx_idle_reg      <= rx_idle_next;
			des_lock_cnt_reg <= des_lock_cnt_next;
			hold_reg         <= hold_next;
			lock_out_reg     <= lock_out_next;
			pd_out_reg       <= pd_out_next;
			eq_reg           <= eq_next;
		end
	end

	// Deserializer output shaping state
	logic              pclk_out_reg, pclk_out_next;
	logic [5:0]        half_cnt_reg, half_cnt_next;
	logic [DATA_W-1:0] data_out_reg, data_out_next;
	logic [DATA_W-1:0] stg_word_reg, stg_word_next;
	logic [7:0]        stg_delay_reg, stg_delay_next;
	logic [1:0]        stg_cnt_reg, stg_cnt_next;
	logic              stg_busy_reg, stg_busy_next;
	logic [7:0]        lfsr_reg, lfsr_next;
	logic [3:0]        tri_reg, tri_next;
	logic              tri_up_reg, tri_up_next;
	logic [7:0]        step_cnt_reg, step_cnt_next;
	logic [7:0]        step_len;
	logic [6:0]        ssc_prod;
	logic [5:0]        half_len;
	logic              half_done;
	logic              launch;

	// Spread spectrum stretches the half period along a triangle
	always_comb
	begin
		if (spread_spectrum_clock_gen_i.rate_sel == 2'h0)
			step_len = SSC_STEP_CYC_0;
		else if (spread_spectrum_clock_gen_i.rate_sel == 2'h1)
			step_len = SSC_STEP_CYC_1;
		else if (spread_spectrum_clock_gen_i.rate_sel == 2'h2)
			step_len = SSC_STEP_CYC_2;
		else
			step_len = SSC_STEP_CYC_3;
		ssc_prod = 7'(tri_reg) * (7'(spread_spectrum_clock_gen_i.dev_sel) + 7'h01);
		half_len = DES_HALF_BASE;
		if (spread_spectrum_clock_gen_i.enable)
			half_len = DES_HALF_BASE + 6'(ssc_prod[6:3]);
	end

	assign half_done = (half_cnt_reg >= half_len - 6'h01);
	// New data goes out on the edge opposite the strobe edge
	assign launch    = half_done && (pclk_out_reg == rx_clock_edge_select_i);

	always_comb
	begin
		pclk_out_next  = pclk_out_reg;
		half_cnt_next  = half_cnt_reg;
		data_out_next  = data_out_reg;
		stg_word_next  = stg_word_reg;
		stg_delay_next = stg_delay_reg;
		stg_cnt_next   = stg_cnt_reg;
		stg_busy_next  = stg_busy_reg;
		lfsr_next      = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
		tri_next       = tri_reg;
		tri_up_next    = tri_up_reg;
		step_cnt_next  = step_cnt_reg + 8'h01;
		if (step_cnt_reg >= step_len - 8'h01)
		begin
			step_cnt_next = 8'h00;
			if (tri_up_reg)
			begin
				tri_next    = tri_reg + 4'h1;
				tri_up_next = (tri_reg + 4'h1 != SSC_TRI_MAX);
			end
			else
			begin
				tri_next    = tri_reg - 4'h1;
				tri_up_next = (tri_reg == 4'h1);
			end
		end
		if (pd_out_reg)
		begin
			pclk_out_next = output_sleep_state_select_i;
			data_out_next = {DATA_W{output_sleep_state_select_i}};
			half_cnt_next = 6'h00;
			stg_busy_next = 1'b0;
		end
		else if (!lock_out_reg)
		begin
			// No valid data is shown until lock is reported
			pclk_out_next = 1'b0;
			data_out_next = '0;
			half_cnt_next = 6'h00;
			stg_busy_next = 1'b0;
		end
		else
		begin
			half_cnt_next = half_done ? 6'h00 : half_cnt_reg + 6'h01;
			if (half_done)
				pclk_out_next = !pclk_out_reg;
			// Each nibble lands at its own random offset in the window
			if (stg_busy_reg)
			begin
				for (int g = 0; g < STAGGER_GROUPS; g++)
					if (stg_delay_reg[2*g +: 2] == stg_cnt_reg)
						data_out_next[STAGGER_GRP_W*g +: STAGGER_GRP_W] =
							stg_word_reg[STAGGER_GRP_W*g +: STAGGER_GRP_W];
				stg_cnt_next  = stg_cnt_reg + 2'h1;
				stg_busy_next = (stg_cnt_reg != STAGGER_LAST);
			end
			if (launch)
			begin
				stg_word_next  = hold_reg;
				stg_delay_next = stagger_enable_i ? lfsr_reg : 8'h00;
				stg_cnt_next   = 2'h0;
				stg_busy_next  = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge des_powerdown_n_pin_i)
	begin
		if (!des_powerdown_n_pin_i)
		begin
			pclk_out_reg  <= 1'b0;
			half_cnt_reg  <= 6'h00;
			data_out_reg  <= '0;
			stg_word_reg  <= '0;
			stg_delay_reg <= 8'h00;
			stg_cnt_reg   <= 2'h0;
			stg_busy_reg  <= 1'b0;
			lfsr_reg      <= LFSR_SEED;
			tri_reg       <= 4'h0;
			tri_up_reg    <= 1'b1;
			step_cnt_reg  <= 8'h00;
		end
		else if (reset_i)
		begin
			pclk_out_reg  <= 1'b0;
			half_cnt_reg  <= 6'h00;
			data_out_reg  <= '0;
			stg_word_reg  <= '0;
			stg_delay_reg <= 8'h00;
			stg_cnt_reg   <= 2'h0;
			stg_busy_reg  <= 1'b0;
			lfsr_reg      <= LFSR_SEED;
			tri_reg       <= 4'h0;
			tri_up_reg    <= 1'b1;
			step_cnt_reg  <= 8'h00;
		end
		else
		begin
			pclk_out_reg  <= pclk_out_next;
			half_cnt_reg  <= half_cnt_next;
			data_out_reg  <= data_out_next;
			stg_word_reg  <= stg_word_next;
			stg_delay_reg <= stg_delay_next;
			stg_cnt_reg   <= stg_cnt_next;
			stg_busy_reg  <= stg_busy_next;
			lfsr_reg      <= lfsr_next;
			tri_reg       <= tri_next;
			tri_up_reg    <= tri_up_next;
			step_cnt_reg  <= step_cnt_next;
		end
	end

	assign des_pclk_o          = pclk_out_reg;
	assign des_data_o          = data_out_reg;
	assign des_lock_o          = lock_out_reg;
	assign des_powered_down_o  = pd_out_reg;
	assign receive_equalizer_o = eq_reg;

endmodule : spc_power_edge_ctrl
`default_nettype wire

/* File: tb/spc_link_peer.sv */
// Far-side link peer: takes serializer words, feeds receiver words
`timescale 1ns/100ps
`default_nettype none
module spc_link_peer
	import spc_pkg::*;
(
	// Clock and bench commands
	input wire logic				ref_clk_i,
	input wire logic				stall_i,
	input wire logic				send_i,
	input wire logic [DATA_W-1:0]	word_i,
	// Link toward the block
	input wire spc_link_word_type	tx_word_i,
	input wire logic				tx_valid_i,
	output logic					tx_ready_o = 1'b0,
	output spc_link_word_type		rx_word_o = TX_STATIC_HIGH,
	output logic					rx_valid_o = 1'b0
);
	logic [DATA_W-1:0]	got[$];
	logic				flip;
	// Undo the balancing inversion of each accepted pixel word
	always @(posedge ref_clk_i)
		if (tx_valid_i && tx_ready_o && !tx_word_i.ctrl)
			got.push_back(tx_word_i.inv ? ~tx_word_i.data : tx_word_i.data);
	// Random stalls; a quiet line shows the inverse of its last word
	always @(negedge ref_clk_i)
	begin
		flip = 1'($urandom);
		tx_ready_o <= !stall_i && 1'($urandom);
		rx_valid_o <= send_i;
		rx_word_o <= send_i ? {1'b0, flip, flip ? ~word_i : word_i} : ~rx_word_o;
	end
endmodule : spc_link_peer
`default_nettype wire

/* File: tb/spc_power_edge_ctrl_tb.sv */
// Self-checking bench for the power and edge controller
`timescale 1ns/100ps
`default_nettype none
module spc_power_edge_ctrl_tb;
	import spc_pkg::*;
	// Counters, model queue and pins named as the ports
	int					error_cnt = 0;
	int					n_tests = 0;
	logic [DATA_W-1:0]	exp_q[$];
	logic				ref_clk_i = 1'b0;
	logic				reset_i = 1'b1;
	logic				ser_powerdown_n_pin_i, ser_auto_mode_i, tx_clock_edge_select_i, pclk_i;
	logic				des_powerdown_n_pin_i, des_auto_mode_i, rx_clock_edge_select_i;
	logic				output_sleep_state_select_i, stagger_enable_i, rx_valid_i, tx_ready_i;
	logic				tx_valid_o, ser_locked_o, ser_on_osc_o, ser_overflow_o, ser_fifo_ready_o;
	logic				des_pclk_o, des_lock_o, des_powered_down_o, stall, send;
	logic [2:0]			receive_equalizer_level_i, receive_equalizer_o;
	logic [DATA_W-1:0]	pixel_data_i, des_data_o, word;
	spc_link_word_type	tx_word_o, rx_word_i;
	spc_ssc_cfg_type	spread_spectrum_clock_gen_i;
	spc_power_edge_ctrl u_dut (.*);
	spc_link_peer u_peer (.ref_clk_i, .stall_i(stall), .send_i(send), .word_i(word),
		.tx_word_i(tx_word_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i),
		.rx_word_o(rx_word_i), .rx_valid_o(rx_valid_i));
	initial forever #50 ref_clk_i = ~ref_clk_i;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc
	// Pixel clock toggles; the model keeps pixels met on the chosen edge
	task automatic pix(input int n);
		repeat (n)
		begin
			pclk_i = ~pclk_i;
			pixel_data_i = DATA_W'($urandom);
			if (ser_locked_o === 1'b1 && pclk_i == tx_clock_edge_select_i)
				exp_q.push_back(pixel_data_i);
			cyc(2);
		end
	endtask : pix
	task automatic drain();
		while (u_peer.got.size() > 0)
			chk(u_peer.got.pop_front(), exp_q.pop_front());
	endtask : drain
	// Bounded wait for the output pixel clock level; n is the cycles taken
	task automatic wait_pclk(input logic v, output int n);
		n = 0;
		while (des_pclk_o !== v && n < 99)
		begin
			cyc(1);
			n++;
		end
	endtask : wait_pclk
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// Watchdog far beyond the run's needs
	initial
	begin
		repeat (6000) @(posedge ref_clk_i);
		error_cnt++;
		end_sim();
	end
	initial
	begin
		int					n;
		int					lim;
		logic [DATA_W-1:0]	old;
		void'($urandom(32'hED7F23A5));
		{ser_powerdown_n_pin_i, des_powerdown_n_pin_i, tx_clock_edge_select_i} = 3'h7;
		{ser_auto_mode_i, des_auto_mode_i, rx_clock_edge_select_i, pclk_i, stall, send} = 6'h00;
		{output_sleep_state_select_i, stagger_enable_i, receive_equalizer_level_i} = 5'h00;
		spread_spectrum_clock_gen_i = 5'h00;
		pixel_data_i = 16'h0000;
		word = 16'h0000;
		cyc(20);
		reset_i = 1'b0;
		// Both halves held off by their pins
		ser_powerdown_n_pin_i = 1'b0;
		des_powerdown_n_pin_i = 1'b0;
		cyc(2);
		chk(tx_word_o, TX_STATIC_HIGH);
		chk(tx_valid_o, 1'b0);
		chk(des_powered_down_o, 1'b1);
		des_powerdown_n_pin_i = 1'b1;
		// Relock after a powerdown pulse, then stream on each edge choice
		for (int s = 1; s >= 0; s--)
		begin
			tx_clock_edge_select_i = 1'(s);
			ser_powerdown_n_pin_i = 1'b0;
			cyc(1);
			ser_powerdown_n_pin_i = 1'b1;
			pix(40);
			chk(ser_locked_o, 1'b1);
			cyc(14);
			u_peer.got.delete();
			exp_q.delete();
			pix(60);
			cyc(15);
			drain();
			chk(exp_q.size(), 0);
		end
		// Pixel clock lost in auto mode, then back
		ser_auto_mode_i = 1'b1;
		cyc(30);
		chk(ser_on_osc_o, 1'b1);
		pix(40);
		chk(ser_locked_o, 1'b1);
		// Far side stalls until the buffer refuses, then drains it
		cyc(14);
		u_peer.got.delete();
		exp_q.delete();
		stall = 1'b1;
		pix(30);
		chk(ser_fifo_ready_o, 1'b0);
		chk(ser_overflow_o, 1'b1);
		stall = 1'b0;
		cyc(15);
		chk(ser_fifo_ready_o, 1'b1);
		drain();
		// Locked stream under each strobe edge and stagger choice
		send = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			rx_clock_edge_select_i = k[0];
			stagger_enable_i = k[1];
			receive_equalizer_level_i = 3'($urandom);
			spread_spectrum_clock_gen_i = 5'($urandom);
			lim = 16 + (spread_spectrum_clock_gen_i.enable ? 1 + spread_spectrum_clock_gen_i.dev_sel : 0);
			cyc(80);
			chk(des_lock_o, 1'b1);
			chk(receive_equalizer_o, receive_equalizer_level_i);
			old = word;
			wait_pclk(!k[0], n);
			wait_pclk(k[0], n);
			word = DATA_W'($urandom);
			wait_pclk(!k[0], n);
			chk(des_data_o, old);
			chk(n >= 16 && n <= lim, 1'b1);
			wait_pclk(k[0], n);
			chk(des_data_o, word);
		end
		// Stream stops in auto mode; sleeping outputs show the chosen level
		des_auto_mode_i = 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			output_sleep_state_select_i = 1'(s);
			send = 1'b0;
			cyc(60);
			chk(des_powered_down_o, 1'b1);
			chk({des_pclk_o, des_data_o}, {17{1'(s)}});
			send = 1'b1;
			cyc(30);
			chk(des_lock_o, 1'b1);
		end
		end_sim();
	end
endmodule : spc_power_edge_ctrl_tb
`default_nettype wire

/* File: tb/spc_props.sv */
// Checker on the controller's ports
`timescale 1ns/100ps
`default_nettype none
module spc_props
	import spc_pkg::*;
(
	// Serializer side
	input wire logic				ref_clk_i,
	input wire logic				reset_i,
	input wire logic				ser_powerdown_n_pin_i,
	input wire logic				pclk_i,
	input wire spc_link_word_type	tx_word_o,
	input wire logic				tx_valid_o,
	input wire logic				tx_ready_i,
	input wire logic				ser_locked_o,
	// Deserializer side
	input wire logic				des_powerdown_n_pin_i,
	input wire logic				output_sleep_state_select_i,
	input wire logic [2:0]			receive_equalizer_level_i,
	input wire logic				rx_valid_i,
	input wire logic				des_pclk_o,
	input wire logic [DATA_W-1:0]	des_data_o,
	input wire logic				des_lock_o,
	input wire logic				des_powered_down_o,
	input wire logic [2:0]			receive_equalizer_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// Quiet-spell counters saturate, so a long idle never wraps to zero
	logic [5:0]	pclk_idle_reg;
	logic [5:0]	rx_idle_reg;
	logic		pclk_last_reg;
	always_ff @(posedge ref_clk_i)
	begin
		pclk_last_reg <= pclk_i;
		pclk_idle_reg <= (pclk_i != pclk_last_reg) ? 6'h00 : pclk_idle_reg + 6'(~&pclk_idle_reg);
		rx_idle_reg <= rx_valid_i ? 6'h00 : rx_idle_reg + 6'(~&rx_idle_reg);
	end
	// Two asleep cycles with a steady select
	sequence s_asleep;
		des_powered_down_o && des_powerdown_n_pin_i ##1
		des_powered_down_o && des_powerdown_n_pin_i && $stable(output_sleep_state_select_i);
	endsequence
	a_ser_pd_static: assert property (!ser_powerdown_n_pin_i |->
		tx_word_o == TX_STATIC_HIGH && !tx_valid_o) else $error("link not static high");
	a_des_pd_clear: assert property (!des_powerdown_n_pin_i |->
		des_powered_down_o && !des_lock_o && receive_equalizer_o == 3'h0) else $error("rx not off");
	a_sleep_level: assert property (s_asleep |-> des_pclk_o == output_sleep_state_select_i &&
		des_data_o == {DATA_W{output_sleep_state_select_i}}) else $error("wrong sleep level");
	a_eq_follow: assert property (!des_powered_down_o ##1 !des_powered_down_o |->
		receive_equalizer_o == $past(receive_equalizer_level_i)) else $error("equalizer stale");
	a_lock_awake: assert property (des_lock_o |-> !des_powered_down_o)
		else $error("lock while asleep");
	a_tx_held: assert property (tx_valid_o && !tx_ready_i |=> !ser_powerdown_n_pin_i ||
		tx_valid_o && $stable(tx_word_o)) else $error("word changed before accept");
	a_pclk_loss: assert property (pclk_idle_reg > 6'h16 |-> !ser_locked_o)
		else $error("lock kept without pixel clock");
	a_stream_loss: assert property (rx_idle_reg > 6'h35 |-> !des_lock_o)
		else $error("lock kept without stream");
endmodule : spc_props
bind spc_power_edge_ctrl spc_props u_props (.ref_clk_i, .reset_i, .ser_powerdown_n_pin_i, .pclk_i,
	.tx_word_o, .tx_valid_o, .tx_ready_i, .ser_locked_o, .des_powerdown_n_pin_i,
	.output_sleep_state_select_i, .receive_equalizer_level_i, .rx_valid_i, .des_pclk_o,
	.des_data_o, .des_lock_o, .des_powered_down_o, .receive_equalizer_o);
`default_nettype wire
